/* src/dcbsl_loader.sv */
// Boot stream loader for a dual-core processor: source select, stream parsing, block copy and core start.
// Assumes core_clk at 50 MHz; pins and the host serial link are asynchronous and are synchronised here.
`timescale 1ns/1ns
`include "dcbsl_defs.svh"

// Overview of operation
// - After reset core B idles, core A runs boot program from fixed ROM address.
// - Mode pins select bypass, parallel flash, SPI host or serial EEPROM boot.
// - Bypass skips the boot program and fetches from the external address, 16-bit.
// - Parallel modes default to 3 hold, 15 access and 4 setup cycles.
// - Parallel flash boot uses asynchronous memory bank zero.
// - SPI host boot makes us a slave; host clock at most a quarter of ours.
// - EEPROM boot selects the EEPROM, sends read at address zero, streams bytes in.
// - After all blocks load, core A jumps to its instruction memory start.
// - The boot program moves to interrupt level 15 and stays there.
// - Outside bypass, soft reset flag set skips the boot and jumps to instruction memory start.
// - Core B leaves idle once core A software clears its idle bit.
// - Stream opens with a 4-byte global header carrying a signature.
// - Global header bit 0 selects 16-bit flash when set, 8-bit when clear.
// - Header bits 1-4 give wait states, bits 6-7 hold cycles, bit 5 unused.
// - Header bits 8-10 select serial bit rate 500k, 1M or 2M.
// - Header bits 28-31 hold the signature; bits 11-27 are ignored.
// - An image count block with a 10-byte header follows the global header.
// - Block header is address, byte count, then 2-byte flag word.
// - The image count block is skipped, not copied, since its ignore flag is set.
// - Multi-byte fields arrive least significant byte first.
// - After a final block, stop parsing and jump at interrupt level 15.
module dcbsl_loader (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic [1:0] boot_source_pins,
	input wire logic [15:0] reset_config_register,
	input wire logic [15:0] core_a_sys_config,
	input wire logic [15:0] flash_data,
	input wire logic spi_sck,
	input wire logic spi_mosi,
	input wire logic spi_ss_n,
	input wire logic eeprom_miso,
	output logic [31:0] core_a_pc,
	output logic core_a_run,
	output logic [3:0] core_a_ivg,
	output logic [31:0] core_b_pc,
	output logic core_b_run,
	output logic boot_done,
	output logic boot_error,
	output dcbsl_pkg::dcbsl_timing_s bus_timing,
	output logic [31:0] flash_addr,
	output logic flash_rd_n,
	output logic eeprom_select_out_n,
	output logic eeprom_sck,
	output logic eeprom_mosi,
	output dcbsl_pkg::dcbsl_mem_wr_s mem_wr
);
	import dcbsl_pkg::*;

	dcbsl_state_e state_reg;
	dcbsl_flash_e fl_phase_reg;
	logic [1:0] start_cnt_reg;
	logic [3:0] byte_idx_reg;
	logic [31:0] gh_reg;
	logic [79:0] bh_reg;
	logic [15:0] flags_reg;
	logic [31:0] rem_reg;
	logic [31:0] wr_addr_reg;
	logic src_valid_reg;
	logic [7:0] src_byte_reg;
	logic [1:0] mode_meta_reg;
	logic [1:0] mode_reg;
	logic [15:0] fdata_meta_reg;
	logic [15:0] fdata_reg;
	logic [2:0] spi_meta_reg;
	logic [2:0] spi_sync_reg;
	logic sck_prev_reg;
	logic [2:0] spi_bits_reg;
	logic [7:0] spi_shift_reg;
	logic spi_done_reg;
	logic miso_meta_reg;
	logic miso_reg;
	logic [3:0] fl_cnt_reg;
	logic [31:0] fl_byte_addr_reg;
	logic [7:0] fl_byte_reg;
	logic fl_done_reg;
	logic [2:0] baud_reg;
	logic [4:0] ee_bits_reg;
	logic [23:0] ee_out_reg;
	logic [7:0] ee_in_reg;
	logic [6:0] ee_div_reg;
	logic ee_cmd_done_reg;
	logic ee_done_reg;
	logic consume;
	logic fetch_want;
	logic byte_in_valid;
	logic [7:0] byte_in;
	logic [31:0] gh_new;
	logic [79:0] bh_new;
	logic [6:0] ee_half;
	logic ee_active;
	logic app_running;

	function automatic logic wants_byte(input dcbsl_state_e st);
		wants_byte = (st == ST_GHDR) || (st == ST_BHDR) || (st == ST_DATA);
	endfunction

	assign consume = src_valid_reg && wants_byte(state_reg);
	assign fetch_want = wants_byte(state_reg) && !src_valid_reg;
	assign gh_new = {src_byte_reg, gh_reg[31:8]};
	assign bh_new = {src_byte_reg, bh_reg[79:8]};
	assign ee_active = (ee_bits_reg != 5'h00) || eeprom_sck;
	assign app_running = (state_reg == ST_DONE) || (state_reg == ST_BYPASS);

	always_comb begin
		case (mode_reg)
			`DCBSL_MODE_FLASH: begin
				byte_in_valid = fl_done_reg;
				byte_in = fl_byte_reg;
			end
			`DCBSL_MODE_SPI_HOST: begin
				byte_in_valid = spi_done_reg;
				byte_in = spi_shift_reg;
			end
			`DCBSL_MODE_EEPROM: begin
				byte_in_valid = ee_done_reg;
				byte_in = ee_in_reg;
			end
			default: begin
				byte_in_valid = 1'b0;
				byte_in = 8'h00;
			end
		endcase
	end

	always_comb begin
		case (baud_reg)
			3'h1: ee_half = 7'(`DCBSL_HALF_CYC(`DCBSL_BAUD_1M_HZ) - 1);
			3'h2: ee_half = 7'(`DCBSL_HALF_CYC(`DCBSL_BAUD_2M_HZ) - 1);
			default: ee_half = 7'(`DCBSL_HALF_CYC(`DCBSL_BAUD_500K_HZ) - 1);
		endcase
	end

	// Pin synchronisers.
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			mode_meta_reg <= 2'h0;
			mode_reg <= 2'h0;
			fdata_meta_reg <= 16'h0000;
			fdata_reg <= 16'h0000;
			spi_meta_reg <= 3'h4;
			spi_sync_reg <= 3'h4;
			sck_prev_reg <= 1'b0;
			miso_meta_reg <= 1'b0;
			miso_reg <= 1'b0;
		end else begin
			mode_meta_reg <= boot_source_pins;
			mode_reg <= mode_meta_reg;
			fdata_meta_reg <= flash_data;
			fdata_reg <= fdata_meta_reg;
			spi_meta_reg <= {spi_ss_n, spi_mosi, spi_sck};
			spi_sync_reg <= spi_meta_reg;
			sck_prev_reg <= spi_sync_reg[0];
			miso_meta_reg <= eeprom_miso;
			miso_reg <= miso_meta_reg;
		end
	end

	// Holding byte between the active source and the parser; a new byte wins over consumption.
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			src_valid_reg <= 1'b0;
			src_byte_reg <= 8'h00;
		end else if (byte_in_valid) begin
			src_valid_reg <= 1'b1;
			src_byte_reg <= byte_in;
		end else if (consume) begin
			src_valid_reg <= 1'b0;
		end
	end

	// SPI slave receiver, MSB first, sampled on the host clock's rising edge.
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			spi_bits_reg <= 3'h0;
			spi_shift_reg <= 8'h00;
			spi_done_reg <= 1'b0;
		end else begin
			spi_done_reg <= 1'b0;
			if (spi_sync_reg[2] || mode_reg != `DCBSL_MODE_SPI_HOST) begin
				spi_bits_reg <= 3'h0;
			end else if (spi_sync_reg[0] && !sck_prev_reg) begin
				spi_shift_reg <= {spi_shift_reg[6:0], spi_sync_reg[1]};
				spi_bits_reg <= spi_bits_reg + 3'h1;
				spi_done_reg <= (spi_bits_reg == 3'h7);
			end
		end
	end

	// Parallel flash reader: setup, access and hold phases per byte.
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			fl_phase_reg <= FL_IDLE;
			fl_cnt_reg <= 4'h0;
			fl_byte_addr_reg <= `DCBSL_BYPASS_ADDR;
			fl_byte_reg <= 8'h00;
			fl_done_reg <= 1'b0;
			flash_addr <= `DCBSL_BYPASS_ADDR;
			flash_rd_n <= 1'b1;
		end else begin
			fl_done_reg <= 1'b0;
			case (fl_phase_reg)
				FL_IDLE: begin
					if (mode_reg == `DCBSL_MODE_FLASH && fetch_want) begin
						flash_addr <= bus_timing.width16 ? {fl_byte_addr_reg[31:1], 1'b0} : fl_byte_addr_reg;
						fl_cnt_reg <= bus_timing.setup;
						fl_phase_reg <= FL_SETUP;
					end
				end
				FL_SETUP: begin
					if (fl_cnt_reg <= 4'h1) begin
						flash_rd_n <= 1'b0;
						fl_cnt_reg <= bus_timing.access;
						fl_phase_reg <= FL_ACCESS;
					end else begin
						fl_cnt_reg <= fl_cnt_reg - 4'h1;
					end
				end
				FL_ACCESS: begin
					if (fl_cnt_reg <= 4'h1) begin
						flash_rd_n <= 1'b1;
						fl_byte_reg <= (bus_timing.width16 && fl_byte_addr_reg[0]) ? fdata_reg[15:8] : fdata_reg[7:0];
						fl_done_reg <= 1'b1;
						fl_byte_addr_reg <= fl_byte_addr_reg + 32'h1;
						fl_cnt_reg <= bus_timing.hold;
						fl_phase_reg <= FL_HOLD;
					end else begin
						fl_cnt_reg <= fl_cnt_reg - 4'h1;
					end
				end
				FL_HOLD: begin
					if (fl_cnt_reg <= 4'h1) begin
						fl_phase_reg <= FL_IDLE;
					end else begin
						fl_cnt_reg <= fl_cnt_reg - 4'h1;
					end
				end
				default: fl_phase_reg <= FL_IDLE;
			endcase
		end
	end

	// Serial EEPROM master, mode 0: one read command, then a byte clocked in per request.
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			eeprom_select_out_n <= 1'b1;
			eeprom_sck <= 1'b0;
			eeprom_mosi <= 1'b0;
			ee_bits_reg <= 5'h00;
			ee_out_reg <= 24'h000000;
			ee_in_reg <= 8'h00;
			ee_div_reg <= 7'h00;
			ee_cmd_done_reg <= 1'b0;
			ee_done_reg <= 1'b0;
		end else begin
			ee_done_reg <= 1'b0;
			if (state_reg == ST_DONE || state_reg == ST_ABORT || state_reg == ST_JUMP) begin
				eeprom_select_out_n <= 1'b1;
				eeprom_sck <= 1'b0;
				ee_bits_reg <= 5'h00;
			end else if (mode_reg == `DCBSL_MODE_EEPROM && state_reg == ST_GHDR && eeprom_select_out_n) begin
				eeprom_select_out_n <= 1'b0;
				ee_bits_reg <= `DCBSL_EE_CMD_BITS;
				ee_out_reg <= {`DCBSL_EE_READ_CMD, `DCBSL_EE_START_ADDR};
				eeprom_mosi <= 1'(`DCBSL_EE_READ_CMD >> 7);
				ee_div_reg <= ee_half;
			end else if (ee_active) begin
				if (ee_div_reg == 7'h00) begin
					ee_div_reg <= ee_half;
					eeprom_sck <= !eeprom_sck;
					if (!eeprom_sck) begin
						ee_in_reg <= {ee_in_reg[6:0], miso_reg};
						ee_bits_reg <= ee_bits_reg - 5'h01;
						if (ee_bits_reg == 5'h01) begin
							ee_done_reg <= ee_cmd_done_reg;
							ee_cmd_done_reg <= 1'b1;
						end
					end else begin
						ee_out_reg <= {ee_out_reg[22:0], 1'b0};
						eeprom_mosi <= ee_out_reg[22];
					end
				end else begin
					ee_div_reg <= ee_div_reg - 7'h01;
				end
			end else if (ee_cmd_done_reg && fetch_want && !eeprom_select_out_n) begin
				ee_bits_reg <= `DCBSL_EE_BYTE_BITS;
				ee_div_reg <= ee_half;
			end
		end
	end

	// Stream parser: global header, block headers, payload copy, zero fill.
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			state_reg <= ST_RESET;
			start_cnt_reg <= 2'h0;
			byte_idx_reg <= 4'h0;
			gh_reg <= 32'h0;
			bh_reg <= 80'h0;
			flags_reg <= 16'h0000;
			rem_reg <= 32'h0;
			wr_addr_reg <= 32'h0;
		end else begin
			case (state_reg)
				ST_RESET: begin
					start_cnt_reg <= start_cnt_reg + 2'h1;
					if (start_cnt_reg == `DCBSL_START_WAIT) state_reg <= ST_DECIDE;
				end
				ST_DECIDE: begin
					byte_idx_reg <= 4'h0;
					if (mode_reg == `DCBSL_MODE_BYPASS) state_reg <= ST_BYPASS;
					else if (reset_config_register[`DCBSL_SOFT_RESET_BIT]) state_reg <= ST_DONE;
					else state_reg <= ST_GHDR;
				end
				ST_GHDR: begin
					if (consume) begin
						gh_reg <= gh_new;
						byte_idx_reg <= byte_idx_reg + 4'h1;
						if (byte_idx_reg == `DCBSL_GH_LAST_IDX) begin
							byte_idx_reg <= 4'h0;
							if (gh_new[31:28] == `DCBSL_GH_SIGNATURE) state_reg <= ST_BHDR;
							else state_reg <= ST_ABORT;
						end
					end
				end
				ST_BHDR: begin
					if (consume) begin
						bh_reg <= bh_new;
						byte_idx_reg <= byte_idx_reg + 4'h1;
						if (byte_idx_reg == `DCBSL_BH_LAST_IDX) begin
							byte_idx_reg <= 4'h0;
							wr_addr_reg <= bh_new[31:0];
							rem_reg <= bh_new[63:32];
							flags_reg <= bh_new[79:64];
							if (bh_new[63:32] != 32'h0) begin
								state_reg <= bh_new[64 + `DCBSL_FLAG_ZEROFILL] ? ST_FILL : ST_DATA;
							end else if (bh_new[64 + `DCBSL_FLAG_FINAL]) begin
								state_reg <= ST_JUMP;
							end
						end
					end
				end
				ST_DATA, ST_FILL: begin
					if (consume || state_reg == ST_FILL) begin
						rem_reg <= rem_reg - 32'h1;
						wr_addr_reg <= wr_addr_reg + 32'h1;
						if (rem_reg == 32'h1) state_reg <= flags_reg[`DCBSL_FLAG_FINAL] ? ST_JUMP : ST_BHDR;
					end
				end
				ST_JUMP: state_reg <= ST_DONE;
				ST_DONE, ST_ABORT, ST_BYPASS: state_reg <= state_reg;
				default: state_reg <= ST_RESET;
			endcase
		end
	end

	// Memory writes for payload and zero fill; ignored payload blocks are skipped, but zero fill is written even when the ignore flag is set.
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			mem_wr <= '0;
		end else begin
			mem_wr.valid <= (state_reg == ST_FILL) ||
				(state_reg == ST_DATA && consume && !flags_reg[`DCBSL_FLAG_IGNORE]);
			mem_wr.addr <= wr_addr_reg;
			mem_wr.data <= (state_reg == ST_FILL) ? 8'h00 : src_byte_reg;
		end
	end

	// External bus timing: slowest defaults, then global header fields.
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			bus_timing.width16 <= 1'b0;
			bus_timing.bank <= `DCBSL_FLASH_BANK;
			bus_timing.setup <= `DCBSL_SETUP_DEF;
			bus_timing.access <= `DCBSL_ACCESS_DEF;
			bus_timing.hold <= `DCBSL_HOLD_DEF;
			baud_reg <= 3'h0;
		end else if (state_reg == ST_DECIDE && mode_reg == `DCBSL_MODE_BYPASS) begin
			bus_timing.width16 <= 1'b1;
		end else if (state_reg == ST_GHDR && consume && byte_idx_reg == `DCBSL_GH_LAST_IDX &&
			gh_new[31:28] == `DCBSL_GH_SIGNATURE) begin
			bus_timing.width16 <= gh_new[`DCBSL_GH_WIDTH_BIT];
			bus_timing.access <= gh_new[`DCBSL_GH_WAIT_MSB:`DCBSL_GH_WAIT_LSB];
			bus_timing.hold <= {2'h0, gh_new[`DCBSL_GH_HOLD_MSB:`DCBSL_GH_HOLD_LSB]};
			baud_reg <= gh_new[`DCBSL_GH_BAUD_MSB:`DCBSL_GH_BAUD_LSB];
		end
	end

	// Core control: boot ROM fetch, interrupt level, application start and core B release.
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			core_a_pc <= `DCBSL_BOOT_ROM_ADDR;
			core_a_run <= 1'b1;
			core_a_ivg <= `DCBSL_IVG_RESET;
			core_b_pc <= `DCBSL_CORE_B_START_ADDR;
			core_b_run <= 1'b0;
			boot_done <= 1'b0;
			boot_error <= 1'b0;
		end else begin
			boot_done <= app_running;
			if (state_reg == ST_DECIDE) begin
				if (mode_reg == `DCBSL_MODE_BYPASS) begin
					core_a_pc <= `DCBSL_BYPASS_ADDR;
				end else begin
					core_a_ivg <= `DCBSL_IVG_BOOT;
					if (reset_config_register[`DCBSL_SOFT_RESET_BIT]) core_a_pc <= `DCBSL_L1_START_ADDR;
				end
			end
			if (state_reg == ST_JUMP) core_a_pc <= `DCBSL_L1_START_ADDR;
			if (state_reg == ST_ABORT) begin
				core_a_run <= 1'b0;
				boot_error <= 1'b1;
			end
			if (app_running && !core_a_sys_config[`DCBSL_CORE_B_IDLE_BIT]) core_b_run <= 1'b1;
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!resetn);

	sequence s_bad_sig;
		state_reg == ST_GHDR && consume && byte_idx_reg == `DCBSL_GH_LAST_IDX &&
			src_byte_reg[7:4] != `DCBSL_GH_SIGNATURE;
	endsequence
	sequence s_jump;
		state_reg == ST_JUMP;
	endsequence

	property p_rom_start;
		state_reg == ST_RESET |-> core_a_pc == `DCBSL_BOOT_ROM_ADDR && !core_b_run;
	endproperty
	a_rom_start: assert property (p_rom_start) else $error("Core A not at boot ROM during start.");
	property p_bypass;
		state_reg == ST_DECIDE && mode_reg == `DCBSL_MODE_BYPASS |=>
			core_a_pc == `DCBSL_BYPASS_ADDR && state_reg == ST_BYPASS && core_a_ivg == `DCBSL_IVG_RESET;
	endproperty
	a_bypass: assert property (p_bypass) else $error("Bypass did not start external fetch.");
	property p_ivg;
		state_reg == ST_DECIDE && mode_reg != `DCBSL_MODE_BYPASS |=> core_a_ivg == `DCBSL_IVG_BOOT;
	endproperty
	a_ivg: assert property (p_ivg) else $error("Boot program not at level 15.");
	property p_soft_reset;
		state_reg == ST_DECIDE && mode_reg != `DCBSL_MODE_BYPASS && reset_config_register[`DCBSL_SOFT_RESET_BIT]
			|=> state_reg == ST_DONE && core_a_pc == `DCBSL_L1_START_ADDR;
	endproperty
	a_soft_reset: assert property (p_soft_reset) else $error("Soft reset did not skip boot.");
	property p_core_b;
		$rose(core_b_run) |-> !$past(core_a_sys_config[`DCBSL_CORE_B_IDLE_BIT]) && $past(app_running);
	endproperty
	a_core_b: assert property (p_core_b) else $error("Core B released without idle bit clear.");
	property p_bad_sig;
		s_bad_sig |=> (state_reg == ST_ABORT && !mem_wr.valid)[*3];
	endproperty
	a_bad_sig: assert property (p_bad_sig) else $error("Bad signature did not abort.");
	property p_final_jump;
		s_jump |=> state_reg == ST_DONE && core_a_pc == `DCBSL_L1_START_ADDR && core_a_ivg == `DCBSL_IVG_BOOT;
	endproperty
	a_final_jump: assert property (p_final_jump) else $error("Final block did not jump to L1.");
	property p_fill;
		state_reg == ST_FILL && !consume |=> mem_wr.valid && mem_wr.data == 8'h00 && !$past(src_valid_reg && !byte_in_valid) || src_valid_reg;
	endproperty
	a_fill: assert property (p_fill) else $error("Zero fill wrong or consumed payload.");
	property p_ignore;
		state_reg == ST_DATA && consume && flags_reg[`DCBSL_FLAG_IGNORE] |=> !mem_wr.valid;
	endproperty
	a_ignore: assert property (p_ignore) else $error("Ignored block was written.");
	property p_defaults;
		state_reg == ST_GHDR && byte_idx_reg == 4'h0 |-> bus_timing.access == `DCBSL_ACCESS_DEF &&
			bus_timing.hold == `DCBSL_HOLD_DEF && bus_timing.setup == `DCBSL_SETUP_DEF && bus_timing.bank == `DCBSL_FLASH_BANK;
	endproperty
	a_defaults: assert property (p_defaults) else $error("Bus timing not at defaults.");
	property p_ee_sel;
		mode_reg == `DCBSL_MODE_EEPROM && state_reg == ST_BHDR |-> !eeprom_select_out_n;
	endproperty
	a_ee_sel: assert property (p_ee_sel) else $error("EEPROM not selected while loading.");

endmodule

/* src/dcbsl_defs.svh */
// Constants of the dual-core boot stream loader: addresses, field positions, defaults and timing counts.
// Assumes inclusion by the loader package and module; holds definitions only.
`ifndef DCBSL_DEFS_SVH
`define DCBSL_DEFS_SVH

`define DCBSL_CLK_HZ 50000000
`define DCBSL_BOOT_ROM_ADDR 32'hEF00_0000
`define DCBSL_BYPASS_ADDR 32'h2000_0000
`define DCBSL_L1_START_ADDR 32'hFFA0_0000
`define DCBSL_CORE_B_START_ADDR 32'hFF60_0000
`define DCBSL_MODE_BYPASS 2'h0
`define DCBSL_MODE_FLASH 2'h1
`define DCBSL_MODE_SPI_HOST 2'h2
`define DCBSL_MODE_EEPROM 2'h3
`define DCBSL_SETUP_DEF 4'h4
`define DCBSL_ACCESS_DEF 4'hF
`define DCBSL_HOLD_DEF 4'h3
`define DCBSL_FLASH_BANK 2'h0
`define DCBSL_IVG_RESET 4'h0
`define DCBSL_IVG_BOOT 4'hF
`define DCBSL_SOFT_RESET_BIT 4
`define DCBSL_CORE_B_IDLE_BIT 5
`define DCBSL_GH_WIDTH_BIT 0
`define DCBSL_GH_WAIT_MSB 4
`define DCBSL_GH_WAIT_LSB 1
`define DCBSL_GH_HOLD_MSB 7
`define DCBSL_GH_HOLD_LSB 6
`define DCBSL_GH_BAUD_MSB 10
`define DCBSL_GH_BAUD_LSB 8
`define DCBSL_GH_SIGNATURE 4'hA
`define DCBSL_GH_LAST_IDX 4'h3
`define DCBSL_BH_LAST_IDX 4'h9
`define DCBSL_FLAG_ZEROFILL 0
`define DCBSL_FLAG_IGNORE 4
`define DCBSL_FLAG_FINAL 15
`define DCBSL_EE_READ_CMD 8'h03
`define DCBSL_EE_START_ADDR 16'h0000
`define DCBSL_EE_CMD_BITS 5'h18
`define DCBSL_EE_BYTE_BITS 5'h08
`define DCBSL_BAUD_500K_HZ 500000
`define DCBSL_BAUD_1M_HZ 1000000
`define DCBSL_BAUD_2M_HZ 2000000
`define DCBSL_HALF_CYC(hz) ((`DCBSL_CLK_HZ + 2 * (hz) - 1) / (2 * (hz)))
`define DCBSL_START_WAIT 2'h3

`endif

/* src/dcbsl_pkg.sv */
// Types of the dual-core boot stream loader: parser states, bus timing and memory write carriers.
// Assumes the constants header is on the include path.
`include "dcbsl_defs.svh"

package dcbsl_pkg;

	typedef enum logic [3:0] {
		ST_RESET = 4'h0,
		ST_DECIDE = 4'h1,
		ST_GHDR = 4'h3,
		ST_BHDR = 4'h2,
		ST_DATA = 4'h6,
		ST_FILL = 4'h7,
		ST_JUMP = 4'h5,
		ST_DONE = 4'h4,
		ST_ABORT = 4'hC,
		ST_BYPASS = 4'hD
	} dcbsl_state_e;

	typedef enum logic [1:0] {
		FL_IDLE = 2'h0,
		FL_SETUP = 2'h1,
		FL_ACCESS = 2'h3,
		FL_HOLD = 2'h2
	} dcbsl_flash_e;

	typedef struct packed {
		logic width16;
		logic [1:0] bank;
		logic [3:0] setup;
		logic [3:0] access;
		logic [3:0] hold;
	} dcbsl_timing_s;

	typedef struct packed {
		logic valid;
		logic [31:0] addr;
		logic [7:0] data;
	} dcbsl_mem_wr_s;

endpackage

/* tb/dcbsl_spi_host.sv */
// SPI boot host model that pushes a boot stream into the loader, mode 0, MSB first.
// Assumes the loader core clock; the host clock runs at one eighth of it, 160 ns a period.
`timescale 1ns/1ns
module dcbsl_spi_host (
	input wire logic core_clk,
	output logic spi_sck,
	output logic spi_mosi,
	output logic spi_ss_n
);
	initial begin
		spi_sck = 1'b0;
		spi_mosi = 1'b1;
		spi_ss_n = 1'b1;
	end

	// The host drives the serial clock, well under a quarter of the core clock.
	task automatic send_byte(input logic [7:0] b);
		spi_ss_n = 1'b0;
		for (int i = 7; i >= 0; i--) begin
			spi_mosi = b[i];
			repeat (4) @(negedge core_clk);
			spi_sck = 1'b1;
			repeat (4) @(negedge core_clk);
			spi_sck = 1'b0;
		end
	endtask

	// Deselects and leaves the released data line at the inverse of its last value.
	task automatic release_bus();
		repeat (4) @(negedge core_clk);
		spi_ss_n = 1'b1;
		spi_mosi = ~spi_mosi;
	endtask
endmodule

/* tb/dcbsl_loader_tb_top.sv */
// Self-checking bench of the boot stream loader: boot sources, stream parsing and core start.
// Assumes the loader package and the SPI host model are compiled first.
`timescale 1ns/1ns
module dcbsl_loader_tb_top;
	import dcbsl_pkg::*;
	logic core_clk = 1'b0;
	logic resetn = 1'b0;
	logic [1:0] boot_source_pins = 2'h0;
	logic [15:0] reset_config_register = 16'h0000;
	logic [15:0] core_a_sys_config = 16'h0020;
	logic spi_sck, spi_mosi, spi_ss_n, core_a_run, core_b_run, boot_done, boot_error, flash_rd_n;
	logic eeprom_select_out_n, eeprom_sck, eeprom_mosi;
	logic [31:0] core_a_pc, core_b_pc, flash_addr;
	logic [3:0] core_a_ivg;
	dcbsl_timing_s bus_timing;
	dcbsl_mem_wr_s mem_wr;
	logic [31:0] wr_addr[$];
	logic [7:0] wr_data[$];
	int num_errors = 0;
	int checks_done = 0;
	int cycles = 0;
	logic ee_miso = 1'b0;
	int ee_rise = 0;
	logic [7:0] ee_stream[14] = '{8'hDE, 8'h02, 8'h00, 8'hA0, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h80};

	always #10 core_clk = ~core_clk;

	dcbsl_spi_host host (.core_clk, .spi_sck, .spi_mosi, .spi_ss_n);

	// Serial EEPROM partner: counts the command clocks, then shifts its stream out MSB first on each fall.
	always @(posedge eeprom_sck or posedge eeprom_select_out_n) begin
		ee_rise = (eeprom_select_out_n === 1'b1) ? 0 : ee_rise + 1;
	end
	always @(negedge eeprom_sck) begin
		if (eeprom_select_out_n === 1'b0 && ee_rise >= 24 && ee_rise < 136) begin
			ee_miso <= ee_stream[(ee_rise - 24) / 8][7 - (ee_rise - 24) % 8];
		end
	end

	dcbsl_loader dut (.core_clk, .resetn, .boot_source_pins, .reset_config_register, .core_a_sys_config,
		.flash_data(16'h0000), .spi_sck, .spi_mosi, .spi_ss_n, .eeprom_miso(ee_miso), .core_a_pc, .core_a_run,
		.core_a_ivg, .core_b_pc, .core_b_run, .boot_done, .boot_error, .bus_timing, .flash_addr, .flash_rd_n,
		.eeprom_select_out_n, .eeprom_sck, .eeprom_mosi, .mem_wr);

	task automatic print_verdict();
		$display("checks_done=%0d num_errors=%0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// Records every byte written to memory and cuts a hang short.
	always @(posedge core_clk) begin
		cycles++;
		if (mem_wr.valid === 1'b1) begin
			wr_addr.push_back(mem_wr.addr);
			wr_data.push_back(mem_wr.data);
		end
		if (cycles == 30000) begin
			num_errors++;
			print_verdict();
		end
	end

	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		checks_done++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic start(input logic [1:0] pins, input logic [15:0] cfg);
		@(negedge core_clk);
		resetn = 1'b0;
		boot_source_pins = pins;
		reset_config_register = cfg;
		wr_addr.delete();
		wr_data.delete();
		repeat (4) @(negedge core_clk);
		resetn = 1'b1;
	endtask

	task automatic wait_end();
		for (int i = 0; i < 4000 && boot_done !== 1'b1 && boot_error !== 1'b1; i++) @(negedge core_clk);
		repeat (2) @(negedge core_clk);
	endtask

	task automatic send(input logic [7:0] s[]);
		@(negedge core_clk);
		foreach (s[i]) host.send_byte(s[i]);
		host.release_bus();
	endtask

	initial begin
		logic [23:0] cmd;
		int n;
		time t0;
		repeat (4) @(negedge core_clk);
		check(core_a_pc, 32'hEF00_0000);
		check({core_a_run, core_b_run, core_a_ivg}, 32'h0000_0020);
		check(bus_timing, {17'h0, 1'b0, 2'h0, 4'h4, 4'hF, 4'h3});
		start(2'h0, 16'h0000);
		wait_end();
		check(core_a_pc, 32'h2000_0000);
		check(boot_done, 1'b1);
		check(core_b_run, 1'b0);
		core_a_sys_config = 16'h0000;
		repeat (3) @(negedge core_clk);
		check({core_b_run, core_b_pc}, {1'b1, 32'hFF60_0000});
		core_a_sys_config = 16'h0020;
		start(2'h2, 16'h0010);
		wait_end();
		check(core_a_pc, 32'hFFA0_0000);
		check(wr_addr.size(), 0);
		start(2'h1, 16'h0000);
		for (int i = 0; i < 200 && flash_rd_n !== 1'b0; i++) @(negedge core_clk);
		check({flash_rd_n, flash_addr}, {1'b0, 32'h2000_0000});
		check(bus_timing.bank, 2'h0);
		for (n = 0; n < 40 && flash_rd_n === 1'b0; n++) @(negedge core_clk);
		check(n, 15);
		start(2'h3, 16'h0000);
		for (int i = 0; i < 24; i++) begin
			@(posedge eeprom_sck);
			cmd = {cmd[22:0], eeprom_mosi};
		end
		check({eeprom_select_out_n, cmd}, {1'b0, 24'h03_0000});
		repeat (33) @(posedge eeprom_sck);
		t0 = $time;
		@(negedge eeprom_sck);
		check(($time - t0) / 20, 13);
		wait_end();
		check({boot_done, boot_error, eeprom_select_out_n, core_a_pc}, {3'h5, 32'hFFA0_0000});
		start(2'h2, 16'h0000);
		// Count block has count 4 and ignore flag; then two data bytes; then a final zero-fill.
		send('{8'hEF, 8'hFA, 8'hFF, 8'hAF, 8'h11, 8'h22, 8'h33, 8'h44, 8'h04, 8'h00, 8'h00, 8'h00,
			8'h10, 8'h00, 8'h05, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hA0, 8'hFF, 8'h02, 8'h00,
			8'h00, 8'h00, 8'h00, 8'h00, 8'h5A, 8'hC3, 8'h10, 8'h00, 8'hA0, 8'hFF, 8'h03, 8'h00,
			8'h00, 8'h00, 8'h01, 8'h80});
		wait_end();
		check(wr_addr.size(), 5);
		for (int i = 0; i < 5; i++) begin
			check(wr_addr[i], (i < 2) ? 32'hFFA0_0000 + i : 32'hFFA0_000E + i);
			check(wr_data[i], (i == 0) ? 8'h5A : (i == 1) ? 8'hC3 : 8'h00);
		end
		check({boot_done, boot_error, core_a_pc}, {2'h2, 32'hFFA0_0000});
		check(core_a_ivg, 4'hF);
		check({bus_timing.width16, bus_timing.access, bus_timing.hold}, {1'b1, 4'h7, 4'h3});
		check(boot_error, 1'b0);
		start(2'h2, 16'h0000);
		send('{8'h00, 8'h00, 8'h00, 8'h50, 8'h00, 8'h00, 8'hA0, 8'hFF});
		wait_end();
		check({boot_error, core_a_run, boot_done}, 3'h4);
		check(wr_addr.size(), 0);
		print_verdict();
	end
endmodule
